//--- design/eval_rom_port_halt_wake.v
// How it works
// - fetch 8-bit bytes from external memory, 1024 words, via two address groups.
// - manual reset low clears scan outputs and forces program counter to zero.
// - four key inputs with pull-ups; a low key with its wake enable set releases instruction halt.
// - each key and R line has a wake enable; only enabled lines wake.
// - scan outputs set or cleared singly or together, driven open-drain low.
// - external halt pin halts, but instruction halt takes precedence over it.
// - four-bit two-way R port with per-bit pull-up enables; low lines with wake enable set wake.
`timescale 1ns/100ps
`default_nettype none
`include "erphw_consts.vh"

module eval_rom_port_halt_wake (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    output reg  [3:0]  prog_addr_low,
    output reg  [5:0]  prog_addr_high,
    input  wire [7:0]  prog_data_in,
    input  wire        manual_reset_n,
    input  wire        ext_halt,
    input  wire [3:0]  key_inputs,
    input  wire [3:0]  key_wake_enable,
    input  wire [3:0]  rport_wake_enable,
    input  wire [3:0]  bidir_port_lines_in,
    output wire [3:0]  bidir_port_lines_out,
    output reg  [3:0]  bidir_port_lines_oe,
    input  wire [3:0]  bidir_pullup_enable,
    output reg  [3:0]  bidir_pullup_on,
    output wire [7:0]  scan_outputs_out,
    output reg  [7:0]  scan_outputs_oe,
    output wire        halted
);

    // count is worked out as an integer, then cut to the counter's width
    localparam integer FETCH_LAST_I = `ERPHW_FETCH_CYC - 1;
    localparam [`ERPHW_CNT_W-1:0] FETCH_LAST =
        FETCH_LAST_I[`ERPHW_CNT_W-1:0];

    // every pin input crosses two flops before any logic looks at it
    wire [`ERPHW_SYNC_W-1:0] pins_raw;
    wire [`ERPHW_SYNC_W-1:0] pins_s;

    assign pins_raw = {prog_data_in, manual_reset_n, ext_halt, key_inputs,
                       key_wake_enable, rport_wake_enable,
                       bidir_port_lines_in, bidir_pullup_enable};

    erphw_sync #(
        .W (`ERPHW_SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pins_raw),
        .q       (pins_s)
    );

    wire [7:0] data_s    = pins_s[29:22];
    wire       init_n_s  = pins_s[21];
    wire       ext_hlt_s = pins_s[20];
    wire [3:0] key_s     = pins_s[19:16];
    wire [3:0] kwen_s    = pins_s[15:12];
    wire [3:0] rwen_s    = pins_s[11:8];
    wire [3:0] rin_s     = pins_s[7:4];
    wire [3:0] rpu_s     = pins_s[3:0];

    reg  [`ERPHW_PC_W-1:0]   pc_reg;
    reg  [`ERPHW_PC_W-1:0]   pc_next;
    wire [`ERPHW_PC_W-1:0]   addr_next;
    reg  [`ERPHW_SCAN_W-1:0] scan_reg;
    reg  [`ERPHW_SCAN_W-1:0] scan_next;
    reg  [`ERPHW_PORT_W-1:0] rport_reg;
    reg  [7:0]               fetch_reg;
    reg  [`ERPHW_CNT_W-1:0]  cnt_reg;
    reg  [`ERPHW_CNT_W-1:0]  cnt_next;
    reg                      ihalt_reg;
    reg                      ihalt_next;

    // apb: write takes effect in the access phase, zero wait states
    wire setup_ph = psel & ~penable;
    wire wr_acc   = psel & penable & pwrite;
    assign pready = 1'b1;

    wire wr_scan  = wr_acc && (paddr == `ERPHW_OFF_SCAN);
    wire wr_set   = wr_acc && (paddr == `ERPHW_OFF_SCAN_SET);
    wire wr_clr   = wr_acc && (paddr == `ERPHW_OFF_SCAN_CLR);
    wire wr_rport = wr_acc && (paddr == `ERPHW_OFF_RPORT);
    wire wr_halt  = wr_acc && (paddr == `ERPHW_OFF_HALT)
                    && pwdata[`ERPHW_HALT_BIT];
    wire wr_pc    = wr_acc && (paddr == `ERPHW_OFF_PC);

    wire wake = |(kwen_s & ~key_s) | |(rwen_s & ~rin_s);

    wire ext_halted = ext_hlt_s & ~ihalt_reg;
    assign halted   = ihalt_reg | ext_halted;

    // instruction halt: a halt command beats a wake in the same cycle
    always @* begin
        ihalt_next = ihalt_reg;
        if (wake) begin
            ihalt_next = 1'b0;
        end
        if (wr_halt) begin
            ihalt_next = 1'b1;
        end
    end

    // scan latch: whole write, set mask, clear mask
    always @* begin
        scan_next = scan_reg;
        if (wr_scan) begin
            scan_next = pwdata[`ERPHW_SCAN_W-1:0];
        end
        if (wr_clr) begin
            scan_next = scan_next & ~pwdata[`ERPHW_SCAN_W-1:0];
        end
        if (wr_set) begin
            scan_next = scan_next | pwdata[`ERPHW_SCAN_W-1:0];
        end
    end

    // fetch: hold the address for the access time, then take the byte
    always @* begin
        pc_next  = pc_reg;
        cnt_next = cnt_reg;
        if (!halted) begin
            if (cnt_reg == FETCH_LAST) begin
                cnt_next = `ERPHW_CNT_ZERO;
                pc_next  = pc_reg + 10'h001;
            end else begin
                cnt_next = cnt_reg + `ERPHW_CNT_ONE;
            end
        end
        if (wr_pc) begin
            pc_next  = pwdata[`ERPHW_PC_W-1:0];
            cnt_next = `ERPHW_CNT_ZERO;
        end
    end

    // core state; manual reset acts while its pin is held low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg    <= `ERPHW_PC_RST;
            scan_reg  <= `ERPHW_SCAN_RST;
            rport_reg <= `ERPHW_RPORT_RST;
            fetch_reg <= `ERPHW_DATA_RST;
            cnt_reg   <= `ERPHW_CNT_ZERO;
            ihalt_reg <= 1'b0;
        end else begin
            ihalt_reg <= ihalt_next;
            if (wr_rport) begin
                rport_reg <= pwdata[`ERPHW_PORT_W-1:0];
            end
            if (!halted && cnt_reg == FETCH_LAST) begin
                fetch_reg <= data_s;
            end
            if (!init_n_s) begin
                pc_reg   <= `ERPHW_PC_RST;
                scan_reg <= `ERPHW_SCAN_RST;
                cnt_reg  <= `ERPHW_CNT_ZERO;
            end else begin
                pc_reg   <= pc_next;
                scan_reg <= scan_next;
                cnt_reg  <= cnt_next;
            end
        end
    end

    // pin drivers from flops; open-drain outputs only ever pull low
    assign scan_outputs_out     = `ERPHW_SCAN_RST;
    assign bidir_port_lines_out = 4'h0;

    // address pins show page zero while manual reset is low
    assign addr_next = init_n_s ? pc_next : `ERPHW_PC_RST;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr_low       <= 4'h0;
            prog_addr_high      <= 6'h00;
            scan_outputs_oe     <= `ERPHW_SCAN_RST;
            bidir_port_lines_oe <= 4'h0;
            bidir_pullup_on     <= 4'h0;
        end else begin
            prog_addr_low       <= addr_next[`ERPHW_PCLO_W-1:0];
            prog_addr_high      <= addr_next[`ERPHW_PC_W-1:`ERPHW_PCLO_W];
            // latch one turns the low-side switch on
            scan_outputs_oe     <= init_n_s ? scan_next : `ERPHW_SCAN_RST;
            // latch zero pulls the line low, pull-ups follow pins
            bidir_port_lines_oe <= ~(wr_rport ?
                                    pwdata[`ERPHW_PORT_W-1:0] : rport_reg);
            bidir_pullup_on     <= rpu_s;
        end
    end

    // read data is formed in setup, so it stands from a flop in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `ERPHW_ZERO32;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= 1'b0;
            prdata  <= `ERPHW_ZERO32;
            case (paddr)
                `ERPHW_OFF_SCAN:     prdata <= {24'h0, scan_reg};
                `ERPHW_OFF_SCAN_SET: prdata <= `ERPHW_ZERO32;
                `ERPHW_OFF_SCAN_CLR: prdata <= `ERPHW_ZERO32;
                `ERPHW_OFF_RPORT:    prdata <= {28'h0, rport_reg};
                `ERPHW_OFF_HALT:     prdata <= {31'h0, ihalt_reg};
                `ERPHW_OFF_PC:       prdata <= {22'h0, pc_reg};
                `ERPHW_OFF_STATUS:   prdata <= {20'h0, rin_s, key_s, 1'b0,
                                                ext_halted, ihalt_reg,
                                                halted};
                `ERPHW_OFF_FETCH:    prdata <= {24'h0, fetch_reg};
                default: begin
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

endmodule // eval_rom_port_halt_wake

`default_nettype wire

//--- inc/erphw_consts.vh
`ifndef ERPHW_CONSTS_VH
`define ERPHW_CONSTS_VH

// register byte offsets on the apb window
`define ERPHW_OFF_SCAN     8'h00
`define ERPHW_OFF_SCAN_SET 8'h04
`define ERPHW_OFF_SCAN_CLR 8'h08
`define ERPHW_OFF_RPORT    8'h0C
`define ERPHW_OFF_HALT     8'h10
`define ERPHW_OFF_PC       8'h14
`define ERPHW_OFF_STATUS   8'h18
`define ERPHW_OFF_FETCH    8'h1C

// field widths and positions
`define ERPHW_PC_W         10
`define ERPHW_PCLO_W       4
`define ERPHW_PCHI_W       6
`define ERPHW_SCAN_W       8
`define ERPHW_PORT_W       4
`define ERPHW_HALT_BIT     0
`define ERPHW_SYNC_W       30

// reset values
`define ERPHW_PC_RST       10'h000
`define ERPHW_SCAN_RST     8'h00
`define ERPHW_RPORT_RST    4'hF
`define ERPHW_DATA_RST     8'h00
`define ERPHW_ZERO32       32'h0000_0000

// program memory access time and the clock period, in ns
`define ERPHW_FETCH_NS     200
`define ERPHW_CLK_NS       4
`define ERPHW_FETCH_CYC    ((`ERPHW_FETCH_NS + `ERPHW_CLK_NS - 1) / `ERPHW_CLK_NS)
`define ERPHW_CNT_W        8
`define ERPHW_CNT_ZERO     8'h00
`define ERPHW_CNT_ONE      8'h01

`endif

//--- design/erphw_sync.v
`timescale 1ns/100ps
`default_nettype none

module erphw_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_reg;

    // two flops per bit; only the second stage is visible outside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // erphw_sync

`default_nettype wire

//--- tb/erphw_sva.sv
`timescale 1ns/100ps
`default_nettype none
module erphw_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  prog_addr_low,
    input wire logic [5:0]  prog_addr_high,
    input wire logic        manual_reset_n,
    input wire logic        ext_halt,
    input wire logic [3:0]  key_inputs,
    input wire logic [3:0]  key_wake_enable,
    input wire logic [3:0]  bidir_port_lines_out,
    input wire logic [7:0]  scan_outputs_out,
    input wire logic [7:0]  scan_outputs_oe,
    input wire logic        halted
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // inputs pass two sync flops, so windows allow for that lag
    wire       wr = psel && penable && pwrite;
    wire [9:0] pa = {prog_addr_high, prog_addr_low};
    wire       kw = |(key_wake_enable & ~key_inputs);
    rdy_const_a: assert property (pready)
        else $error("pready low");
    pc_step_a: assert property ((!wr)[*3] ##1 ($changed(pa) && pa != 10'h0)
        |-> pa == $past(pa) + 10'h1) else $error("pc skipped");
    mrst_clear_a: assert property ((!manual_reset_n)[*6]
        |-> pa == 10'h0 && scan_outputs_oe == 8'h00) else $error("no reset");
    key_wake_a: assert property ((kw && !ext_halt)[*5] |=> !halted)
        else $error("no wake");
    open_drain_a: assert property (scan_outputs_out == 8'h00
        && bidir_port_lines_out == 4'h0) else $error("drives high");
    scan_wr_a: assert property (wr && paddr == 8'h00 && manual_reset_n
        |-> ##2 scan_outputs_oe == $past(pwdata[7:0], 2)) else $error("scan");
    ext_halt_a: assert property (ext_halt[*4] |-> halted)
        else $error("ext halt ignored");
    halt_freeze_a: assert property (halted[*2] |=> $stable(pa))
        else $error("fetch while halted");
    halt_wake_c: cover property (halted ##1 !halted);
    pc_load_c: cover property (wr && paddr == 8'h14);
    bad_addr_c: cover property ($rose(pslverr));
endmodule // erphw_sva
bind eval_rom_port_halt_wake erphw_sva u_sva (.*);
`default_nettype wire

//--- tb/erphw_far.sv
`timescale 1ns/100ps
`default_nettype none
module erphw_far (
    input  wire logic       pclk,
    input  wire logic [3:0] a_lo,
    input  wire logic [5:0] a_hi,
    output logic      [7:0] data,
    input  wire logic [3:0] oe,
    input  wire logic [3:0] pu,
    input  wire logic [3:0] de,
    input  wire logic [3:0] dv,
    output logic      [3:0] lv
);
    logic [3:0] tgl = 4'h5;
    // a released line without pull-up wanders, never a stale level
    always @(posedge pclk) tgl <= ~tgl;
    // rom image is the address mixed with a constant
    assign data = {a_hi[3:0], a_lo} ^ 8'h3C;
    // own pull-down wins, then outside drive, then pull-up
    assign lv = ~oe & ((de & dv) | (~de & (pu | tgl)));
endmodule // erphw_far
`default_nettype wire

//--- tb/eval_rom_port_halt_wake_bench.sv
`timescale 1ns/100ps
`default_nettype none
module eval_rom_port_halt_wake_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, mrst_n = 1'b1, ext = 1'b0, pready, pslverr, e;
    logic halted;
    logic [7:0] paddr = 8'h00, pdat, sout, soe;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] keys = 4'hF, kwe = 4'h0, rwe = 4'h0, rpu = 4'h0;
    logic [3:0] de = 4'hF, dv = 4'hF, alo, rin, rout, roe, rpo;
    logic [5:0] ahi;
    int fail_count = 0, check_count = 0;
    eval_rom_port_halt_wake dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .prog_addr_low(alo),
        .prog_addr_high(ahi), .prog_data_in(pdat), .manual_reset_n(mrst_n),
        .ext_halt(ext), .key_inputs(keys), .key_wake_enable(kwe),
        .rport_wake_enable(rwe), .bidir_port_lines_in(rin),
        .bidir_port_lines_out(rout), .bidir_port_lines_oe(roe),
        .bidir_pullup_enable(rpu), .bidir_pullup_on(rpo),
        .scan_outputs_out(sout), .scan_outputs_oe(soe), .halted(halted));
    erphw_far far_u (.pclk(pclk), .a_lo(alo), .a_hi(ahi), .data(pdat),
        .oe(roe), .pu(rpo), .de(de), .dv(dv), .lv(rin));
    initial forever #2 pclk = ~pclk;
    task automatic ck(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // one apb transfer; answer is taken at the edge that samples pready
    task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wa(input logic [9:0] v);
        int n;
        n = 0;
        while ({ahi, alo} !== v && n < 200) begin
            @(posedge pclk);
            n++;
        end
        ck({ahi, alo}, v);
    endtask
    task automatic t_scan;
        ap(1'b1, 8'h00, 32'h81);
        ap(1'b1, 8'h04, 32'h42);
        ap(1'b1, 8'h08, 32'h01);
        ap(1'b0, 8'h00, 32'h0);
        ck(r, 32'hC2);
        ck(soe, 32'hC2);
        ap(1'b0, 8'h40, 32'h0);
        ck({31'h0, e}, 32'h1);
        ck(r, 32'h0);
    endtask
    task automatic t_mrst;
        ap(1'b1, 8'h00, 32'hFF);
        mrst_n <= 1'b0;
        repeat (8) @(posedge pclk);
        ck({ahi, alo, soe}, 18'h0);
        mrst_n <= 1'b1;
        ap(1'b0, 8'h00, 32'h0);
        ck(r, 32'h0);
    endtask
    task automatic t_fetch;
        ap(1'b1, 8'h14, 32'h3FE);
        wa(10'h3FF);
        ap(1'b0, 8'h1C, 32'h0);
        ck(r, {24'h0, 8'hFE ^ 8'h3C});
        wa(10'h000);
    endtask
    task automatic t_halt(input logic [3:0] k);
        logic [9:0] v;
        ap(1'b1, 8'h10, 32'h1);
        keys <= k;
        repeat (8) @(posedge pclk);
        v = {ahi, alo};
        ck(halted, 1'b1);
        kwe <= ~k;
        repeat (6) @(posedge pclk);
        ck(halted, 1'b0);
        keys <= 4'hF;
        kwe <= 4'h0;
        wa(v + 10'h1);
    endtask
    task automatic t_ext;
        ext <= 1'b1;
        repeat (2) @(posedge pclk);
        ap(1'b0, 8'h18, 32'h0);
        ck(r[2:0], 3'h5);
        ap(1'b1, 8'h10, 32'h1);
        ap(1'b0, 8'h18, 32'h0);
        ck(r[2:0], 3'h3);
        ext <= 1'b0;
        kwe <= 4'h2;
        keys <= 4'hD;
        repeat (6) @(posedge pclk);
        ck(halted, 1'b0);
        keys <= 4'hF;
        kwe <= 4'h0;
    endtask
    task automatic t_rport;
        rpu <= 4'h8;
        de <= 4'h7;
        ap(1'b1, 8'h0C, 32'hE);
        repeat (3) @(posedge pclk);
        ap(1'b0, 8'h18, 32'h0);
        ck({rpo, r[11:8]}, 8'h8E);
        ap(1'b1, 8'h0C, 32'hF);
        ap(1'b1, 8'h10, 32'h1);
        dv <= 4'hB;
        repeat (6) @(posedge pclk);
        ck(halted, 1'b1);
        rwe <= 4'h4;
        repeat (6) @(posedge pclk);
        ck(halted, 1'b0);
        dv <= 4'hF;
        rwe <= 4'h0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_scan;
        t_mrst;
        t_fetch;
        t_halt(4'hE);
        t_halt(4'h7);
        t_ext;
        t_rport;
        results;
    end
    // run needs about 320 cycles; far longer means a hang
    initial begin
        #100000;
        fail_count++;
        results;
    end
endmodule // eval_rom_port_halt_wake_bench
`default_nettype wire
